// [logic/adc_link_pkg.sv]
// Shared constants for the serial converter link: frame layout, counts
// and timing. Assumes a 200 MHz system clock on the host end.
package adc_link_pkg;
    // Frame layout of the 12-bit variant
    localparam int RES_BITS = 12;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] LEAD_ZEROS = 5'h02;
    localparam logic [CNT_W-1:0] CONV_PERIODS_12 = 5'h0e;
    localparam logic [CNT_W-1:0] CONV_PERIODS_10 = 5'h0c;
    localparam logic [CNT_W-1:0] CONV_PERIODS_8 = 5'h0a;
    localparam logic [CNT_W-1:0] CONV_PERIODS = CONV_PERIODS_12;
    localparam logic [CNT_W-1:0] FRAME_SHORT = 5'h0e;
    localparam logic [CNT_W-1:0] FRAME_LONG = 5'h10;
    localparam int SHIFT_W = 16;
    localparam int TRAIL_ZEROS = 2;

    // Timing figures in their own units
    localparam int MCLK_PERIOD_PS = 5000;
    localparam int BUS_QUIET_GAP_NS = 4;
    localparam int ACQUISITION_INTERVAL_NS = 60;
    localparam int FRAME_SETUP_NS = 6;
    localparam int POWERUP_US = 1;
    localparam int SCLK_MAX_KHZ = 48000;
    localparam int SCLK_MIN_KHZ = 500;
    localparam int SYNC_STAGES = 2;

    // Least time in cycles: round up, never below one
    function automatic int cycles_least(input int ps);
        int c;
        c = (ps + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // Longest time in cycles: round down, never below one
    function automatic int cycles_most(input int ps);
        int c;
        c = ps / MCLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int TMR_W = 8;
    localparam int QUIET_CYC = cycles_least(BUS_QUIET_GAP_NS * 1000);
    localparam int ACQ_CYC = cycles_least(ACQUISITION_INTERVAL_NS * 1000);
    localparam int GAP_CYC = (ACQ_CYC > QUIET_CYC) ? ACQ_CYC : QUIET_CYC;
    localparam int SETUP_CYC = cycles_least(FRAME_SETUP_NS * 1000) + SYNC_STAGES;
    localparam int POWERUP_READY_CYC = cycles_most(POWERUP_US * 1000000);
    localparam int POWERUP_WAIT_CYC = cycles_least(POWERUP_US * 1000000);
    // Half period of the shift clock, long enough to stay under the top rate
    localparam int SCLK_HALF_CYC = cycles_least((1000000000 / SCLK_MAX_KHZ + 1) / 2);
    localparam int SCLK_HALF_LIMIT = cycles_most(1000000000 / SCLK_MIN_KHZ / 2);
endpackage

// [logic/adc_link_if.sv]
// Link between converter and host: frame select, shift clock, data pin.
// The data pin is modelled as enable plus value; a released pin reads low.
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
    logic sclk;
    logic frame_n;
    logic sdo;
    logic sdo_oe_n;
    logic bus_level;

    // Resolved pin level as the host sees it
    assign bus_level = sdo_oe_n ? 1'b0 : sdo;

    modport device (input sclk, input frame_n, output sdo, output sdo_oe_n);
    modport host (output sclk, output frame_n, input bus_level);
endinterface
`default_nettype wire

// [logic/adc_device_end.sv]
// Converter end of the serial link: conversion timing and result shifter.
// Assumes the host drives frame select and the shift clock, and holds
// SAMPLE_VALUE steady around the falling edge of frame select.
`timescale 1ns/1ps
`default_nettype none
module adc_device_end
    import adc_link_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic [RES_BITS-1:0] SAMPLE_VALUE,
    output logic READY,
    output logic CONV_DONE,
    output logic [RES_BITS-1:0] RESULT_WORD,
    adc_link_if.device LINK
);

    // Bit to present after a given falling edge count
    function automatic logic frame_bit(input logic [CNT_W-1:0] n,
                                       input logic [RES_BITS-1:0] word);
        logic [CNT_W-1:0] idx;
        idx = CONV_PERIODS - 5'h01 - n;
        if (n < LEAD_ZEROS || n >= CONV_PERIODS) begin
            return 1'b0;
        end
        return word[idx[3:0]];
    endfunction

    logic [RES_BITS-1:0] held_q;
    logic [CNT_W-1:0] fall_cnt_q;
    logic [CNT_W-1:0] fall_cnt_d;
    logic sdo_q;
    logic done_q;
    logic conv_tgl_q;
    logic [SYNC_STAGES-1:0] tgl_sync_q;
    logic tgl_seen_q;
    logic [TMR_W-1:0] pwr_cnt_q;
    logic ready_q;
    logic conv_done_q;
    logic [RES_BITS-1:0] result_q;

    assign fall_cnt_d = fall_cnt_q + 5'h01;

    // Sample taken at the frame select fall, before any shift edge
    always_ff @(negedge LINK.frame_n) begin
        held_q <= SAMPLE_VALUE;
    end

    // Falling edge counter; frame select high clears it, so a frame
    // cut short never leaves stale state for the next one
    always_ff @(negedge LINK.sclk or posedge LINK.frame_n) begin
        if (LINK.frame_n) begin
            fall_cnt_q <= '0;
        end else if (fall_cnt_q != FRAME_LONG) begin
            fall_cnt_q <= fall_cnt_d;
        end
    end

    // Serial data: leading zeros, result MSB first, trailing zeros
    always_ff @(negedge LINK.sclk or posedge LINK.frame_n) begin
        if (LINK.frame_n) begin
            sdo_q <= 1'b0;
        end else if (fall_cnt_q != FRAME_LONG) begin
            sdo_q <= frame_bit(fall_cnt_d, held_q);
        end
    end

    // Release flag after the last falling edge of a long frame
    always_ff @(negedge LINK.sclk or posedge LINK.frame_n) begin
        if (LINK.frame_n) begin
            done_q <= 1'b0;
        end else if (fall_cnt_d == FRAME_LONG) begin
            done_q <= 1'b1;
        end
    end

    // Conversion ends after a fixed count of periods; the event is a
    // toggle so it survives the clock stopping between frames
    always_ff @(negedge LINK.sclk or negedge NRST) begin
        if (!NRST) begin
            conv_tgl_q <= 1'b0;
        end else if (!LINK.frame_n && fall_cnt_d == CONV_PERIODS) begin
            conv_tgl_q <= ~conv_tgl_q;
        end
    end

    assign LINK.sdo = sdo_q;
    // Enable follows frame select directly; a clocked enable would lag
    // the frame start and miss the first leading zero
    assign LINK.sdo_oe_n = LINK.frame_n | done_q;

    // Toggle crossing into the system clock
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            tgl_sync_q <= '0;
            tgl_seen_q <= 1'b0;
        end else begin
            tgl_sync_q <= {tgl_sync_q[0], conv_tgl_q};
            tgl_seen_q <= tgl_sync_q[1];
        end
    end

    // Result handed to the user side once the conversion is over; the
    // held word stays put until the next frame select fall
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            conv_done_q <= 1'b0;
            result_q <= '0;
        end else begin
            conv_done_q <= tgl_sync_q[1] ^ tgl_seen_q;
            if (tgl_sync_q[1] ^ tgl_seen_q) begin
                result_q <= held_q;
            end
        end
    end

    // Power-up timer; ready before the longest allowed delay
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pwr_cnt_q <= '0;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            pwr_cnt_q <= pwr_cnt_q + 8'h01;
            if (pwr_cnt_q == TMR_W'(POWERUP_READY_CYC - 2)) begin
                ready_q <= 1'b1;
            end
        end
    end

    assign READY = ready_q;
    assign CONV_DONE = conv_done_q;
    assign RESULT_WORD = result_q;
endmodule
`default_nettype wire

// [logic/adc_host_end.sv]
// Host end of the serial link: makes the shift clock from MCLK, frames
// each conversion and buffers results in a two-entry queue.
// Assumes the converter end sits on the far side of the link interface.
`timescale 1ns/1ps
`default_nettype none
module adc_host_end
    import adc_link_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic ENABLE,
    input wire logic LONG_FRAME,
    output logic DATA_VALID,
    output logic [RES_BITS-1:0] DATA_WORD,
    input wire logic DATA_READY,
    adc_link_if.host LINK
);

    typedef enum logic [4:0] {
        ST_POWERUP = 5'b00001,
        ST_IDLE = 5'b00010,
        ST_SETUP = 5'b00100,
        ST_SHIFT = 5'b01000,
        ST_GAP = 5'b10000
    } state_type;

    state_type state_q;
    logic [TMR_W-1:0] tmr_q;
    logic [CNT_W-1:0] fall_cnt_q;
    logic [CNT_W-1:0] frame_len_q;
    logic sclk_q;
    logic frame_n_q;
    logic [SYNC_STAGES-1:0] pin_sync_q;
    logic [SHIFT_W-1:0] shift_q;
    logic push;
    logic pop;
    logic [RES_BITS-1:0] push_word;
    logic head_v_q;
    logic tail_v_q;
    logic [RES_BITS-1:0] head_q;
    logic [RES_BITS-1:0] tail_q;

    // Data pin passes two flops before it is read
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pin_sync_q <= '0;
        end else begin
            pin_sync_q <= {pin_sync_q[0], LINK.bus_level};
        end
    end

    // Frame sequencer, shift clock divider and sampler
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= ST_POWERUP;
            tmr_q <= TMR_W'(POWERUP_WAIT_CYC);
            fall_cnt_q <= '0;
            frame_len_q <= FRAME_SHORT;
            sclk_q <= 1'b1;
            frame_n_q <= 1'b1;
            shift_q <= '0;
        end else begin
            case (state_q)
                ST_POWERUP: begin
                    // No frame until the converter is surely awake
                    if (tmr_q == '0) begin
                        state_q <= ST_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                ST_IDLE: begin
                    // Start only with room for the result: back-pressure
                    if (ENABLE && !tail_v_q) begin
                        frame_n_q <= 1'b0;
                        frame_len_q <= LONG_FRAME ? FRAME_LONG : FRAME_SHORT;
                        fall_cnt_q <= '0;
                        tmr_q <= TMR_W'(SETUP_CYC - 1);
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (tmr_q == '0) begin
                        tmr_q <= TMR_W'(SCLK_HALF_CYC - 1);
                        state_q <= ST_SHIFT;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                ST_SHIFT: begin
                    if (tmr_q != '0) begin
                        tmr_q <= tmr_q - 8'h01;
                    end else begin
                        tmr_q <= TMR_W'(SCLK_HALF_CYC - 1);
                        if (sclk_q) begin
                            // Bit shown since the previous fall is taken now
                            shift_q <= {shift_q[SHIFT_W-2:0], pin_sync_q[1]};
                            fall_cnt_q <= fall_cnt_q + 5'h01;
                            sclk_q <= 1'b0;
                        end else begin
                            sclk_q <= 1'b1;
                            if (fall_cnt_q == frame_len_q) begin
                                frame_n_q <= 1'b1;
                                tmr_q <= TMR_W'(GAP_CYC - 1);
                                state_q <= ST_GAP;
                            end
                        end
                    end
                end
                ST_GAP: begin
                    // Covers both the quiet gap and acquisition interval
                    if (tmr_q == '0) begin
                        state_q <= ST_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    frame_n_q <= 1'b1;
                    sclk_q <= 1'b1;
                end
            endcase
        end
    end

    // Result sits above the trailing zeros of a long frame
    assign push = (state_q == ST_SHIFT) && (tmr_q == '0) && !sclk_q &&
                  (fall_cnt_q == frame_len_q);
    assign push_word = (frame_len_q == FRAME_LONG) ?
                       shift_q[RES_BITS+TRAIL_ZEROS-1:TRAIL_ZEROS] :
                       shift_q[RES_BITS-1:0];
    assign pop = head_v_q && DATA_READY;

    // Two-entry queue; head feeds the user port directly
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            head_v_q <= 1'b0;
            tail_v_q <= 1'b0;
            head_q <= '0;
            tail_q <= '0;
        end else begin
            if (pop) begin
                head_v_q <= tail_v_q || push;
                head_q <= tail_v_q ? tail_q : push_word;
                tail_v_q <= tail_v_q && push;
                tail_q <= push_word;
            end else if (push) begin
                if (!head_v_q) begin
                    head_v_q <= 1'b1;
                    head_q <= push_word;
                end else begin
                    tail_v_q <= 1'b1;
                    tail_q <= push_word;
                end
            end
        end
    end

    assign LINK.sclk = sclk_q;
    assign LINK.frame_n = frame_n_q;
    assign DATA_VALID = head_v_q;
    assign DATA_WORD = head_q;
endmodule
`default_nettype wire

// [sim/adc_link_sva.sv]
// Link checker: frame select, shift clock and data pin over time.
// Assumes it sits beside the link interface, all in the MCLK domain.
`timescale 1ns/1ps
`default_nettype none
module adc_link_sva
    import adc_link_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic sclk,
    input wire logic frame_n,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    input wire logic bus_level
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);

    logic [4:0] fall_q;

    // Falls seen in this frame; a frame end clears it
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            fall_q <= 5'h00;
        end else if (frame_n) begin
            fall_q <= 5'h00;
        end else if ($fell(sclk)) begin
            fall_q <= fall_q + 5'h01;
        end
    end

    a_drive_on_select: assert property ($fell(frame_n) |-> !sdo_oe_n)
        else $error("pin not driven at frame start");
    a_release_deselect: assert property (frame_n |-> sdo_oe_n)
        else $error("pin driven while deselected");
    a_release_after_last: assert property (fall_q == FRAME_LONG |-> ##[0:4] sdo_oe_n)
        else $error("pin held after last fall");
    a_frame_falls_exact: assert property ($rose(frame_n)
        |-> (fall_q == FRAME_SHORT) || (fall_q == FRAME_LONG))
        else $error("frame ended at wrong count");
    a_setup_before_fall: assert property ($fell(frame_n) |-> sclk [*4])
        else $error("shift clock fell too soon");
    a_gap_before_next: assert property ($rose(frame_n)
        |-> frame_n [*8] ##1 frame_n [*4])
        else $error("next frame too soon");
    a_half_period: assert property ($fell(sclk) |-> !sclk [*3] ##1 sclk)
        else $error("shift clock low time wrong");
    a_clock_idle_high: assert property (frame_n |-> sclk)
        else $error("shift clock runs outside frame");
    // A driven bit may only move in the same cycle as a shift-clock fall
    a_bit_after_fall: assert property (!sdo_oe_n && $changed(sdo) |-> $fell(sclk))
        else $error("data bit changed without fall");

    c_short_frame: cover property ($rose(frame_n) && fall_q == FRAME_SHORT);
    c_long_frame: cover property ($rose(frame_n) && fall_q == FRAME_LONG);
    c_frame_start: cover property ($fell(frame_n));
endmodule
`default_nettype wire

// [sim/sar_adc_serial_readout_tb_top.sv]
// Bench: host and converter ends joined by the link, checked on the
// wire and at both user sides. Only MCLK is made; host derives sclk.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_readout_tb_top;
    import adc_link_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic enable = 1'b0;
    logic long_frame = 1'b0;
    logic data_ready = 1'b0;
    logic [RES_BITS-1:0] sample_value = 12'h000;
    logic ready;
    logic conv_done;
    logic [RES_BITS-1:0] result_word;
    logic data_valid;
    logic [RES_BITS-1:0] data_word;
    logic [15:0] wire_bits = 16'h0000;
    int error_cnt = 0;
    int n_checks = 0;
    int done_cnt = 0;
    int n_frames = 0;
    int n_falls = 0;
    int n;

    adc_link_if i_adc_link_if ();
    wire logic fr_n = i_adc_link_if.frame_n;
    wire logic oe_n = i_adc_link_if.sdo_oe_n;

    adc_device_end i_adc_device_end (.MCLK(mclk), .NRST(nrst),
        .SAMPLE_VALUE(sample_value), .READY(ready), .CONV_DONE(conv_done),
        .RESULT_WORD(result_word), .LINK(i_adc_link_if));
    adc_host_end i_adc_host_end (.MCLK(mclk), .NRST(nrst), .ENABLE(enable),
        .LONG_FRAME(long_frame), .DATA_VALID(data_valid), .DATA_WORD(data_word),
        .DATA_READY(data_ready), .LINK(i_adc_link_if));
    adc_link_sva i_adc_link_sva (.MCLK(mclk), .NRST(nrst),
        .sclk(i_adc_link_if.sclk), .frame_n(fr_n), .sdo(i_adc_link_if.sdo),
        .sdo_oe_n(oe_n), .bus_level(i_adc_link_if.bus_level));

    always #2.5 mclk = ~mclk;

    // Wire monitor: level present as the shift clock falls
    always @(negedge i_adc_link_if.sclk) begin
        if (!fr_n) begin
            wire_bits = {wire_bits[14:0], i_adc_link_if.bus_level};
            n_falls = n_falls + 1;
        end
    end
    always @(negedge fr_n) begin
        n_frames = n_frames + 1;
        n_falls = 0;
        wire_bits = 16'h0000;
    end
    always @(posedge mclk) begin
        if (conv_done === 1'b1) begin
            done_cnt = done_cnt + 1;
        end
    end

    task automatic summarize();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bounded wait for a frame select level; a hang ends the run
    task automatic wait_frame(input logic lvl);
        int i;
        for (i = 0; i < 600 && fr_n !== lvl; i++) @(negedge mclk);
        if (i == 600) begin
            error_cnt++;
            summarize();
        end
    endtask

    // Take one word from the host buffer
    task automatic read_word(input logic [RES_BITS-1:0] exp);
        int i;
        @(negedge mclk);
        for (i = 0; i < 600 && data_valid !== 1'b1; i++) @(negedge mclk);
        if (i == 600) begin
            error_cnt++;
            summarize();
        end
        check(32'(data_word), 32'(exp));
        data_ready = 1'b1;
        @(negedge mclk);
        data_ready = 1'b0;
    endtask

    // One frame with a known sample, checked on wire and both sides
    task automatic convert(input logic [RES_BITS-1:0] val, input logic lng);
        int dn;
        @(negedge mclk);
        sample_value = val;
        long_frame = lng;
        enable = 1'b1;
        dn = done_cnt;
        wait_frame(1'b0);
        enable = 1'b0;
        wait_frame(1'b1);
        check(32'(n_falls), lng ? 32'h10 : 32'h0e);
        check(32'(wire_bits), lng ? 32'({2'b00, val, 2'b00}) : 32'({2'b00, val}));
        read_word(val);
        check(32'(done_cnt), 32'(dn + 1));
        check(32'(result_word), 32'(val));
    endtask

    initial begin
        repeat (20) @(negedge mclk);
        check(32'({i_adc_link_if.sclk, fr_n, oe_n, data_valid, ready, conv_done}),
            32'h38);
        check(32'({data_word, result_word}), 32'h0);
        nrst = 1'b1;
        for (n = 0; n < 300 && ready !== 1'b1; n++) @(negedge mclk);
        check(32'(n <= 200), 32'h1);
        check(32'(fr_n), 32'h1);
        // Boundary and mixed codes, both frame lengths
        convert(12'h000, 1'b0);
        convert(12'hfff, 1'b1);
        convert(12'ha5c, 1'b0);
        convert(12'h3c1, 1'b1);
        // Receiver stalls: two words fill the buffer, frames stop
        n = n_frames;
        sample_value = 12'h5a3;
        enable = 1'b1;
        wait_frame(1'b0);
        wait_frame(1'b1);
        sample_value = 12'h1c7;
        repeat (600) @(negedge mclk);
        check(32'(n_frames - n), 32'h2);
        enable = 1'b0;
        read_word(12'h5a3);
        read_word(12'h1c7);
        @(negedge mclk);
        check(32'(data_valid), 32'h0);
        // Reset in mid-frame must release the pin
        enable = 1'b1;
        wait_frame(1'b0);
        repeat (20) @(negedge mclk);
        nrst = 1'b0;
        enable = 1'b0;
        repeat (2) @(negedge mclk);
        check(32'({fr_n, oe_n}), 32'h3);
        nrst = 1'b1;
        convert(12'h7e1, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
